/* ecs_pkg.sv */
// package: state and cycle codes, alu operations, register map and core state
package ecs_pkg;

	// ----------------------------------------
	// state codes, bits ordered bit0 bit1 bit2
	// ----------------------------------------
	typedef enum logic [2:0] {
		WAIT_STATE = 3'h0,
		HIGH_ADDRESS_STATE = 3'h1,
		LOW_ADDRESS_STATE = 3'h2,
		INTERRUPT_ACK_ADDRESS_STATE = 3'h3,
		TRANSFER_STATE = 3'h4,
		EXECUTE_STATE_TWO = 3'h5,
		STOPPED_STATE = 3'h6,
		EXECUTE_STATE_ONE = 3'h7
	} ecs_tstate_t;

	// ----------------------------------------
	// cycle codes as bus bits 7:6
	// ----------------------------------------
	typedef enum logic [1:0] {
		FETCH_CYCLE = 2'h0,
		IO_COMMAND_CYCLE = 2'h1,
		DATA_READ_CYCLE = 2'h2,
		MEMORY_WRITE_CYCLE = 2'h3
	} ecs_cycle_t;

	// ----------------------------------------
	// alu operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		ALU_ADD = 4'h0,
		ALU_ADC = 4'h1,
		ALU_SUB = 4'h2,
		ALU_SBB = 4'h3,
		ALU_AND = 4'h4,
		ALU_XOR = 4'h5,
		ALU_OR = 4'h6,
		ALU_CMP = 4'h7,
		ALU_INC = 4'h8,
		ALU_DEC = 4'h9,
		ALU_RLC = 4'ha,
		ALU_RRC = 4'hb,
		ALU_RAL = 4'hc,
		ALU_RAR = 4'hd
	} ecs_alu_op_t;

	// ----------------------------------------
	// register indices, flags, apb map
	// ----------------------------------------
	localparam logic [2:0] REG_A = 3'h0;
	localparam logic [2:0] REG_H = 3'h5;
	localparam logic [2:0] REG_L = 3'h6;
	localparam logic [2:0] REG_M = 3'h7;
	localparam logic [1:0] FLAG_C = 2'h0;
	localparam logic [1:0] FLAG_Z = 2'h1;
	localparam logic [1:0] FLAG_S = 2'h2;
	localparam logic [1:0] FLAG_P = 2'h3;
	localparam logic [7:0] HALT_OPCODE = 8'hff;
	localparam logic [3:0] REFRESH_LAST = 4'he;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STATUS_OFF = 12'h004;
	localparam int CTRL_RUN_BIT = 0;

	// ----------------------------------------
	// whole core state
	// ----------------------------------------
	typedef struct packed {
		ecs_tstate_t st;
		logic ph;
		logic run;
		logic [7:0] ir;
		logic [1:0] cyc;
		ecs_cycle_t ct;
		logic use_pc;
		logic cl;
		logic [6:0][7:0] regs;
		logic [7:0][13:0] stk;
		logic [2:0] sp;
		logic [3:0] fl;
		logic pend;
		logic [7:0] blo;
		logic [7:0] bhi;
		logic [3:0] rfr;
		logic [7:0] dout;
		logic doe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ecs_core_t;

	localparam ecs_core_t CORE_RESET = '{st: LOW_ADDRESS_STATE, run: 1'b1, ct: FETCH_CYCLE,
		use_pc: 1'b1, doe: 1'b1, default: '0};

endpackage

/* ecs_alu.sv */
// 8-bit arithmetic unit with look-ahead carry and rotates
`timescale 1ns/1ps
module ecs_alu import ecs_pkg::*; (
	// operation
	input ecs_alu_op_t op,
	input logic cin,
	// operands
	input logic [7:0] a,
	input logic [7:0] b,
	// result
	output logic [7:0] res,
	output logic cout
);

	logic [7:0] bx;
	logic [7:0] g;
	logic [7:0] p;
	logic [8:0] c;
	logic sub;

	always_comb begin
		bx = b;
		c = 9'h000;
		sub = 1'b0;
		unique case (op)
			ALU_ADC: c[0] = cin;
			ALU_SUB, ALU_CMP: begin
				bx = ~b;
				c[0] = 1'b1;
				sub = 1'b1;
			end
			ALU_SBB: begin
				bx = ~b;
				c[0] = ~cin;
				sub = 1'b1;
			end
			ALU_INC: begin
				bx = 8'h00;
				c[0] = 1'b1;
			end
			ALU_DEC: bx = 8'hff;
			default: ;
		endcase
		g = a & bx;
		p = a ^ bx;
		for (int i = 0; i < 8; i++) begin
			c[i + 1] = g[i] | (p[i] & c[i]);
		end
		res = p ^ c[7:0];
		cout = sub ? ~c[8] : c[8];
		unique case (op)
			ALU_AND: begin
				res = a & b;
				cout = 1'b0;
			end
			ALU_XOR: begin
				res = a ^ b;
				cout = 1'b0;
			end
			ALU_OR: begin
				res = a | b;
				cout = 1'b0;
			end
			ALU_RLC: {cout, res} = {a[7], a[6:0], a[7]};
			ALU_RRC: {cout, res} = {a[0], a[0], a[7:1]};
			ALU_RAL: {cout, res} = {a[7], a[6:0], cin};
			ALU_RAR: {cout, res} = {a[0], cin, a[7:1]};
			default: ;
		endcase
	end

endmodule

/* ecs_core.sv */
// cpu core: state sequencer, address stack, scratch pad, flags, bus and apb access
`timescale 1ns/1ps
// Operation
// - three state outputs carry the code of the present state
// - a cycle runs two address states, one transfer state, two execute states
// - memory holds ready low while busy; core waits until ready
// - a pending interrupt replaces the low address state of the next fetch cycle by the acknowledge state
// - ready ends waiting by moving to the transfer state
// - halt enters the stopped state until an interrupt arrives
// - execute states are skipped when the instruction needs none
// - wait and stopped states last an even number of clocks
// - instructions take one to three cycles, first always a fetch
// - the high address state carries the cycle code on bus bits 7:6
// - cycle codes: fetch, io command, data read, memory write
// - stack and scratch pad refresh in wait, transfer and stopped states
// - eight 14-bit stack entries, one is the program counter
// - call pushes by advancing the pointer, return pops by moving it back
// - three-bit stack pointer wraps and overwrites the oldest entry
// - low address goes out then counts; high counts only on carry
// - addresses are 14 bits wide
// - accumulator and six general registers; arithmetic uses accumulator except increment and decrement
// - memory operands address from h (low six bits) and l
// - alu adds, subtracts, logic ops, compare, increment, decrement with look-ahead carry
// - alu results set carry, zero, sign, parity; conditional flow tests them
// - multi-byte instructions sit in consecutive words, low address before high
// - one bidirectional byte bus, direction set by instruction and state
// - third byte gives upper six address bits, top two ignored
module ecs_core import ecs_pkg::*; (
	// clock and reset
	input logic REF_CLK,
	input logic RST_N,
	// multiplexed memory bus
	input logic [7:0] D_IN,
	output logic [7:0] D_OUT,
	output logic D_OE,
	input logic READY,
	input logic INTR,
	// state outputs
	output logic STATE_CODE_BIT0,
	output logic STATE_CODE_BIT1,
	output logic STATE_CODE_BIT2,
	output logic SYNC,
	// apb slave
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [11:0] PADDR,
	input logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	ecs_core_t q, d;
	logic tick;
	logic [7:0] op;
	logic [2:0] dd;
	logic [2:0] ss;
	logic [13:0] pc;
	logic [7:0] pc_lo;
	logic [5:0] ahi;
	logic [13:0] tgt;
	logic halt, mov, lrm, lmr, alur, imm, lri, lmi, incdec, rot;
	logic ret, rst, jmp, cal, io, inp, cond, taken, last, exec;
	logic [1:0] ncyc;
	ecs_cycle_t nct;
	logic npc;
	ecs_alu_op_t aop;
	logic [7:0] aa;
	logic [7:0] ab;
	logic [7:0] ares;
	logic acout;
	logic [31:0] status;

	// two clocks per state, state moves on the second
	assign tick = q.ph & q.run;
	// the fetched byte is decoded while still on the bus
	assign op = (q.st == TRANSFER_STATE && q.cyc == 2'h0) ? D_IN : q.ir;
	assign dd = op[5:3];
	assign ss = op[2:0];
	assign pc = q.stk[q.sp];
	assign pc_lo = pc[7:0];
	assign tgt = {q.bhi[5:0], q.blo};
	assign halt = (op[7:1] == 7'h00) || (op == HALT_OPCODE);
	assign mov = (op[7:6] == 2'h3) && !halt;
	assign lrm = mov && ss == REG_M;
	assign lmr = mov && dd == REG_M;
	assign alur = op[7:6] == 2'h2;
	assign imm = op[7:6] == 2'h0 && ss == 3'h4;
	assign lri = op[7:6] == 2'h0 && ss == 3'h6;
	assign lmi = lri && dd == REG_M;
	assign incdec = op[7:6] == 2'h0 && ss[2:1] == 2'h0 && !halt;
	assign rot = op[7:6] == 2'h0 && ss == 3'h2;
	assign ret = op[7:6] == 2'h0 && ss[1:0] == 2'h3;
	assign rst = op[7:6] == 2'h0 && ss == 3'h5;
	assign jmp = op[7:6] == 2'h1 && op[1:0] == 2'h0;
	assign cal = op[7:6] == 2'h1 && op[1:0] == 2'h2;
	assign io = op[7:6] == 2'h1 && op[0];
	assign inp = io && op[5:4] == 2'h0;
	assign cond = q.fl[op[4:3]] == op[5];
	assign taken = op[2] || cond;
	assign status = {7'h00, q.pend, pc, q.fl, q.sp, q.st};
	// pc, else io command byte, else h register
	assign ahi = (q.use_pc || q.ct == FETCH_CYCLE) ? pc[13:8] :
		(q.ct == IO_COMMAND_CYCLE ? q.ir[5:0] : q.regs[REG_H][5:0]);

	// ----------------------------------------
	// cycle plan
	// ----------------------------------------
	always_comb begin
		ncyc = 2'h1;
		if (jmp || cal || lmi) begin
			ncyc = 2'h3;
		end else if (lrm || lmr || (alur && ss == REG_M) || imm || lri || io) begin
			ncyc = 2'h2;
		end
	end

	assign last = (q.cyc + 2'h1) == ncyc;
	// stores, output and untaken branches need no execute states
	assign exec = !(lmr || lmi || (io && !inp) || ((ret || jmp || cal) && !taken));

	always_comb begin
		nct = DATA_READ_CYCLE;
		npc = 1'b1;
		if (io) begin
			nct = IO_COMMAND_CYCLE;
			npc = 1'b0;
		end else if (lmr || (lmi && q.cyc == 2'h1)) begin
			nct = MEMORY_WRITE_CYCLE;
			npc = 1'b0;
		end else if (lrm || (alur && ss == REG_M)) begin
			npc = 1'b0;
		end
	end

	// ----------------------------------------
	// alu operands
	// ----------------------------------------
	always_comb begin
		aa = q.regs[REG_A];
		ab = (imm || ss == REG_M) ? q.blo : q.regs[ss];
		aop = ecs_alu_op_t'({1'b0, dd});
		if (incdec) begin
			aa = q.regs[dd];
			aop = ss[0] ? ALU_DEC : ALU_INC;
		end else if (rot) begin
			aop = ecs_alu_op_t'(4'ha + {2'h0, op[4:3]});
		end
	end

	ecs_alu u_alu (
		.op(aop),
		.cin(q.fl[FLAG_C]),
		.a(aa),
		.b(ab),
		.res(ares),
		.cout(acout)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		logic nxt;
		logic fresh;
		nxt = 1'b0;
		fresh = 1'b0;
		d = q;
		d.ph = q.run ? !q.ph : q.ph;
		if (tick) begin
			if (q.st inside {WAIT_STATE, TRANSFER_STATE, STOPPED_STATE}) begin
				d.rfr = (q.rfr == REFRESH_LAST) ? 4'h0 : q.rfr + 4'h1;
			end
			unique case (q.st)
				LOW_ADDRESS_STATE, INTERRUPT_ACK_ADDRESS_STATE: begin
					d.st = HIGH_ADDRESS_STATE;
					d.dout = {q.ct, ahi};
					if (q.use_pc) begin
						{d.cl, d.stk[q.sp][7:0]} = {1'b0, pc[7:0]} + 9'h001;
					end
				end
				HIGH_ADDRESS_STATE, WAIT_STATE: begin
					if (q.st == HIGH_ADDRESS_STATE && q.use_pc) begin
						d.stk[q.sp][13:8] = pc[13:8] + {5'h00, q.cl};
					end
					d.doe = 1'b0;
					if (READY) begin
						d.st = TRANSFER_STATE;
						d.doe = q.ct == MEMORY_WRITE_CYCLE;
						d.dout = lmi ? q.blo : q.regs[ss];
					end else begin
						d.st = WAIT_STATE;
					end
				end
				TRANSFER_STATE: begin
					d.doe = 1'b0;
					if (q.cyc == 2'h0) begin
						d.ir = D_IN;
					end else if (q.cyc == 2'h1) begin
						d.blo = D_IN;
					end else begin
						d.bhi = D_IN;
					end
					if (q.cyc == 2'h0 && halt) begin
						d.st = STOPPED_STATE;
					end else if (!last) begin
						nxt = 1'b1;
					end else if (exec) begin
						d.st = EXECUTE_STATE_ONE;
					end else begin
						fresh = 1'b1;
					end
				end
				EXECUTE_STATE_ONE: begin
					d.st = EXECUTE_STATE_TWO;
				end
				EXECUTE_STATE_TWO: begin
					fresh = 1'b1;
					if (mov || lri) begin
						d.regs[dd] = (lrm || lri) ? q.blo : q.regs[ss];
					end
					if (alur || imm || incdec) begin
						d.fl[FLAG_Z] = ares == 8'h00;
						d.fl[FLAG_S] = ares[7];
						d.fl[FLAG_P] = ~^ares;
					end
					if (alur || imm) begin
						d.fl[FLAG_C] = acout;
						if (dd != 3'h7) begin
							d.regs[REG_A] = ares;
						end
					end
					if (incdec) begin
						d.regs[dd] = ares;
					end
					if (rot) begin
						d.regs[REG_A] = ares;
						d.fl[FLAG_C] = acout;
					end
					if (inp) begin
						d.regs[REG_A] = q.blo;
					end
					if (ret) begin
						d.sp = q.sp - 3'h1;
					end
					if (cal || rst) begin
						d.sp = q.sp + 3'h1;
						d.stk[q.sp + 3'h1] = cal ? tgt : {8'h00, dd, 3'h0};
					end
					if (jmp) begin
						d.stk[q.sp] = tgt;
					end
				end
				STOPPED_STATE: begin
					if (q.pend) begin
						fresh = 1'b1;
					end
				end
			endcase
			if (nxt) begin
				d.cyc = q.cyc + 2'h1;
				d.ct = nct;
				d.use_pc = npc;
			end
			if (fresh) begin
				d.cyc = 2'h0;
				d.ct = FETCH_CYCLE;
				d.use_pc = !q.pend;
				d.pend = 1'b0;
			end
			if (nxt || fresh) begin
				d.st = (fresh && q.pend) ? INTERRUPT_ACK_ADDRESS_STATE : LOW_ADDRESS_STATE;
				d.doe = 1'b1;
				d.dout = (d.use_pc || d.ct == FETCH_CYCLE) ? d.stk[d.sp][7:0] :
					(d.ct == IO_COMMAND_CYCLE ? q.regs[REG_A] : q.regs[REG_L]);
			end
		end
		// a request in the clearing cycle is kept
		if (INTR) begin
			d.pend = 1'b1;
		end

		// apb: answer one cycle into access, write lands at completion
		d.pready = 1'b0;
		if (PSEL && PENABLE && q.pready) begin
			if (PWRITE && PADDR == CTRL_OFF) begin
				d.run = PWDATA[CTRL_RUN_BIT];
			end
		end else if (PSEL && PENABLE) begin
			d.pready = 1'b1;
			d.pslverr = !(PADDR == CTRL_OFF || (PADDR == STATUS_OFF && !PWRITE));
			d.prdata = (PADDR == CTRL_OFF) ? {31'h0, q.run} :
				((PADDR == STATUS_OFF) ? status : 32'h0000_0000);
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			q <= CORE_RESET;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign STATE_CODE_BIT0 = q.st[2];
	assign STATE_CODE_BIT1 = q.st[1];
	assign STATE_CODE_BIT2 = q.st[0];
	assign SYNC = q.ph;
	assign D_OUT = q.dout;
	assign D_OE = q.doe;
	assign PRDATA = q.prdata;
	assign PREADY = q.pready;
	assign PSLVERR = q.pslverr;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	exec_code_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st == EXECUTE_STATE_ONE) |=> {STATE_CODE_BIT0, STATE_CODE_BIT1, STATE_CODE_BIT2} == 3'h5)
		else $error("execute one not followed by execute two code");
	addr_seq_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st == LOW_ADDRESS_STATE) |=> q.st == HIGH_ADDRESS_STATE ##2 q.st != HIGH_ADDRESS_STATE)
		else $error("address states out of order");
	wait_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st inside {HIGH_ADDRESS_STATE, WAIT_STATE} && !READY) |=> q.st == WAIT_STATE)
		else $error("left for transfer without ready");
	ready_ack_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st inside {HIGH_ADDRESS_STATE, WAIT_STATE} && READY) |=> q.st == TRANSFER_STATE)
		else $error("ready not acknowledged by transfer state");
	int_ack_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st == STOPPED_STATE && q.pend) |=> q.st == INTERRUPT_ACK_ADDRESS_STATE && !q.use_pc)
		else $error("interrupt not acknowledged");
	halt_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st == TRANSFER_STATE && q.cyc == 2'h0 && halt) |=> q.st == STOPPED_STATE)
		else $error("halt did not stop");
	dwell_even_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$changed(q.st) |=> $stable(q.st))
		else $error("state held for one clock only");
	cycle_code_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		q.st == HIGH_ADDRESS_STATE |-> D_OE && D_OUT[7:6] == q.ct)
		else $error("cycle code missing on high address");
	pc_count_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st == LOW_ADDRESS_STATE && q.use_pc) |=> pc_lo == $past(pc_lo) + 8'h01)
		else $error("program counter low byte not advanced");
	push_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(tick && q.st == EXECUTE_STATE_TWO && (cal || rst)) |=> q.sp == $past(q.sp) + 3'h1)
		else $error("stack pointer not advanced by push");
	sync_align_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$changed(q.st) |-> !SYNC)
		else $error("state changed off sync boundary");

endmodule

/* ecs_mem.sv */
// memory and io partner on the core's multiplexed bus
`timescale 1ns/1ps
module ecs_mem import ecs_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// core bus
	input wire logic [2:0] st,
	input wire logic sync,
	input wire logic [7:0] d_out,
	output logic [7:0] d_in,
	output logic rdy
);
	logic [7:0] mem [0:16383];
	logic [15:0] rec [$];
	logic [7:0] lo;
	logic [13:0] adr;
	logic [1:0] ct;
	logic done;
	int rem;
	int w;
	initial begin
		d_in = 8'h00;
		rdy = 1'b0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	// ----
	// bus handshake
	// ----
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem <= 0;
			done <= 1'b0;
		end else begin
			w = $urandom_range(2);
			if (st == TRANSFER_STATE && ct != 2'h3) begin
				d_in <= mem[adr];
			end else begin
				d_in <= ~d_in; // released bus keeps moving, no stale byte
			end
			if (st == LOW_ADDRESS_STATE || st == INTERRUPT_ACK_ADDRESS_STATE) begin
				lo <= d_out;
				rem <= w;
				rdy <= (w == 0);
				done <= 1'b0;
			end
			if ((st == HIGH_ADDRESS_STATE || st == WAIT_STATE) && sync && rem != 0) begin
				rem <= rem - 1;
				rdy <= (rem == 1);
			end
			if (st == HIGH_ADDRESS_STATE && sync && !done) begin
				ct <= d_out[7:6];
				adr <= {d_out[5:0], lo};
				done <= 1'b1;
				rec.push_back({d_out, lo});
			end
			if (st == TRANSFER_STATE && sync && ct == 2'h3) mem[adr] <= d_out;
		end
	end
endmodule

/* ecs_core_bench.sv */
// bench for the cpu core: program run, bus cycles, state order, apb status
`timescale 1ns/1ps
module ecs_core_bench import ecs_pkg::*; ();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic intr = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [7:0] d_in, d_out;
	logic d_oe, rdy, s0, s1, s2, sync, pready, pslverr;
	logic [31:0] prdata;
	logic [2:0] st;
	int bad_count = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	assign st = {s0, s1, s2};
	ecs_core u_dut (.REF_CLK(clk), .RST_N(rst_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .READY(rdy),
		.INTR(intr), .STATE_CODE_BIT0(s0), .STATE_CODE_BIT1(s1), .STATE_CODE_BIT2(s2), .SYNC(sync),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	ecs_mem u_mem (.clk(clk), .rst_n(rst_n), .st(st), .sync(sync), .d_out(d_out), .d_in(d_in), .rdy(rdy));
	// ----
	// helpers
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'hffff_ffff;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_st(input logic [2:0] s);
		int n;
		n = 0;
		while (st !== s && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) begin
			bad_count++;
			final_report();
		end
	endtask
	function automatic logic legal(input logic [2:0] a, input logic [2:0] b);
		case (a)
			3'h2, 3'h3: return b == 3'h1;
			3'h1: return b == 3'h0 || b == 3'h4;
			3'h0: return b == 3'h4;
			3'h4: return b inside {3'h7, 3'h2, 3'h3, 3'h6};
			3'h7: return b == 3'h5;
			3'h5: return b inside {3'h2, 3'h3, 3'h6};
			default: return b == 3'h3;
		endcase
	endfunction
	function automatic logic [3:0] flags(input logic [8:0] s);
		return {~^s[7:0], s[7], s[7:0] == 8'h00, s[8]};
	endfunction
	// ----
	// state monitor, sampled mid-clock
	// ----
	logic [2:0] pst;
	logic rdy_s;
	int cnt;
	int acks = 0;
	int waits = 0;
	always @(negedge clk) begin
		if (!rst_n) begin
			pst = LOW_ADDRESS_STATE;
			cnt = 0;
		end else begin
			if (st !== pst) begin
				check(legal(pst, st), 1);
				check(cnt % 2, 0);
				if (pst == 3'h1 || pst == 3'h0) check(st, rdy_s ? 3'h4 : 3'h0);
				if (st == 3'h3) acks++;
				if (st == 3'h0) waits++;
				cnt = 0;
			end
			check(sync, cnt % 2);
			if (cnt % 2 == 1 && st inside {3'h1, 3'h2, 3'h3}) check(d_oe, 1);
			rdy_s = rdy;
			cnt++;
			pst = st;
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		logic [31:0] rd;
		logic err;
		logic [7:0] x, y, h, l, j, b;
		logic [8:0] s;
		logic [7:0] prog [15];
		logic [15:0] ex [$];
		int n;
		n = $urandom(7022);
		x = $urandom;
		y = $urandom;
		h = $urandom;
		h[5] = 1'b1;
		l = $urandom;
		j = $urandom;
		j[5:0] = 6'h00;
		b = $urandom;
		s = {1'b0, x} + y;
		prog = '{8'h06, x, 8'h04, y, 8'h2e, h, 8'h36, l, 8'hf8, 8'h46, 8'hff, j, 8'h51, 8'hff, 8'hff};
		repeat (4) @(posedge clk);
		foreach (prog[i]) u_mem.mem[i] = prog[i];
		u_mem.mem[16'h00ff] = 8'h0e;
		u_mem.mem[16'h0100] = b;
		u_mem.mem[16'h0101] = 8'h07;
		rst_n <= 1'b1;
		wait_st(STOPPED_STATE);
		apb(1'b0, STATUS_OFF, rd, err);
		check(rd[24:0], {1'b0, 14'h000e, flags(s), 3'h0, 3'h6});
		check(err, 0);
		apb(1'b0, 12'h008, rd, err);
		check({err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, STATUS_OFF, rd, err);
		check(err, 1);
		apb(1'b1, CTRL_OFF, rd, err);
		check(err, 0);
		apb(1'b0, CTRL_OFF, rd, err);
		check({err, rd}, 33'h0_0000_0001);
		@(posedge clk);
		intr <= 1'b1;
		@(posedge clk);
		intr <= 1'b0;
		wait_st(INTERRUPT_ACK_ADDRESS_STATE);
		wait_st(STOPPED_STATE);
		check(acks, 1);
		check(waits > 0, 1);
		check(u_mem.mem[{h[5:0], l}], s[7:0]);
		ex = '{16'h0000, 16'h8001, 16'h0002, 16'h8003, 16'h0004, 16'h8005, 16'h0006, 16'h8007, 16'h0008,
			{2'h3, h[5:0], l}, 16'h0009, 16'h800a, 16'h800b, 16'h00ff, 16'h8100, 16'h0101, 16'h000c,
			{8'h51, s[7:0]}, 16'h000d, 16'h000e};
		check(u_mem.rec.size(), ex.size());
		foreach (ex[i]) check(u_mem.rec[i], ex[i]);
		final_report();
	end
endmodule
